// ===== core/cow_defines.svh
// Offsets, field positions, reset values and timing counts for the
// charge option watchdog block. Definitions only.
`ifndef COW_DEFINES_SVH
`define COW_DEFINES_SVH

`define COW_REG_OPTION0 8'h12
`define COW_REG_CHG_CURRENT 8'h14
`define COW_REG_CHG_VOLTAGE 8'h15
`define COW_OPTION0_RESET 16'hE20E
`define COW_BIT_LOW_POWER 15
`define COW_BIT_WD_HI 14
`define COW_BIT_WD_LO 13
`define COW_BIT_AUTO_OFF 12
`define COW_BIT_REV_GOOD 11
`define COW_BIT_AUDIO_AVOID 10
`define COW_BIT_FREQ 9
`define COW_BIT_IREG_EN 1
// Sized to the counter so the long periods do not overflow 32 bits
`define COW_CLK_HZ 35'd100000000
`define COW_WD_SHORT_S 5
`define COW_WD_MID_S 88
`define COW_WD_LONG_S 175
`define COW_WD_SHORT_CYC (`COW_WD_SHORT_S * `COW_CLK_HZ)
`define COW_WD_MID_CYC (`COW_WD_MID_S * `COW_CLK_HZ)
`define COW_WD_LONG_CYC (`COW_WD_LONG_S * `COW_CLK_HZ)
`define COW_AUDIO_MIN_KHZ 25
`define COW_FREQ_FAST_KHZ 1200
`define COW_FREQ_SLOW_KHZ 800

`endif

// ===== core/cow_pkg.sv
// Types for the charge option watchdog block.
// Assumes cow_defines.svh is included by the design files.
package cow_pkg;
    typedef enum logic [1:0] {
        COW_WD_OFF,
        COW_WD_SHORT,
        COW_WD_MID,
        COW_WD_LONG
    } cow_wd_sel_t;

    // One register write from the host interface logic
    typedef struct packed {
        logic       valid;
        logic [7:0] addr;
        logic [15:0] data;
    } cow_wr_t;

    // Controls handed to the converter
    typedef struct packed {
        logic        suspend;
        logic        burst_floor_en;
        logic [10:0] burst_floor_khz;
        logic [10:0] switch_khz;
        logic        ireg_en;
        logic        low_power;
    } cow_ctrl_t;
endpackage

// ===== core/cow_watchdog.sv
// Charge option register upper half with host-write watchdog.
// Assumes the SMBus engine delivers decoded writes as one-cycle pulses
// and that every input is synchronous to sys_clk.
//
// Behaviour
// - Enabled watchdog with no current, voltage or option write in period forces 0 mA.
// - After timeout, current, voltage or period write restarts timer.
// - Period field: 00 off, 01 5 s, 10 88 s, 11 175 s; resets 11.
// - Auto-off bit set and battery pin falling clears regulation enable.
// - Auto-off bit clear leaves regulation enable alone on pin falling.
// - Host may write regulation enable back to 1 after auto clear.
// - Reverse-source good bit drives charger good high in reverse mode.
// - Audio-avoid bit keeps burst frequency above 25 kHz; else none.
// - Frequency bit 0 selects 1200 kHz, 1 selects 800 kHz; resets 1.
// - Period is longest gap between current, voltage or option writes.
`include "cow_defines.svh"

module cow_watchdog
    import cow_pkg::*;
(
    input wire logic sys_clk,            // 100 MHz clock
    input wire logic rst,                // Async reset, high
    input wire cow_wr_t host_wr,         // Decoded register write
    input wire logic [7:0] rd_addr,      // Read address
    output logic [15:0] rd_data,         // Read data, option reg
    input wire logic battery_present_pin, // Low when battery absent
    input wire logic reverse_source_mode, // Reverse-source active
    input wire logic adapter_good,       // Normal charger good cause
    output logic charger_good_output,    // Charger good pin level
    output cow_ctrl_t ctrl,              // Converter controls
    output logic watchdog_expired        // Timeout status
);

    // ----------------------------------------------------------------
    // Host write decode
    // ----------------------------------------------------------------
    logic [15:0] option0;
    logic wr_opt;
    logic wr_cur;
    logic wr_vol;

    // One compare shared by the three register strobes
    function automatic logic wr_hits(input cow_wr_t wr,
        input logic [7:0] addr);
        wr_hits = wr.valid && (wr.addr == addr);
    endfunction

    assign wr_opt = wr_hits(host_wr, `COW_REG_OPTION0);
    assign wr_cur = wr_hits(host_wr, `COW_REG_CHG_CURRENT);
    assign wr_vol = wr_hits(host_wr, `COW_REG_CHG_VOLTAGE);

    // ----------------------------------------------------------------
    // Battery pin edge
    // ----------------------------------------------------------------
    logic bat_q;
    logic bat_fall;

    // Resets to the fitted level; a false edge right after reset
    // is harmless because the auto-off bit resets clear
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            bat_q <= 1'b1;
        end else begin
            bat_q <= battery_present_pin;
        end
    end

    assign bat_fall = bat_q && !battery_present_pin;

    // ----------------------------------------------------------------
    // Field view
    // ----------------------------------------------------------------
    cow_wd_sel_t period_sel;
    logic auto_off;
    logic rev_good_en;
    logic audio_avoid;
    logic freq_slow;
    logic ireg_en;
    logic low_power;

    assign period_sel = cow_wd_sel_t'(
        option0[`COW_BIT_WD_HI:`COW_BIT_WD_LO]);
    assign auto_off = option0[`COW_BIT_AUTO_OFF];
    assign rev_good_en = option0[`COW_BIT_REV_GOOD];
    assign audio_avoid = option0[`COW_BIT_AUDIO_AVOID];
    assign freq_slow = option0[`COW_BIT_FREQ];
    assign ireg_en = option0[`COW_BIT_IREG_EN];
    assign low_power = option0[`COW_BIT_LOW_POWER];

    // ----------------------------------------------------------------
    // Option register
    // ----------------------------------------------------------------
    logic auto_clear;

    assign auto_clear = bat_fall && auto_off;

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            option0 <= `COW_OPTION0_RESET;
        end else begin
            if (wr_opt) begin
                option0 <= host_wr.data;
            end
            // Hardware clear wins over a same-cycle host write
            if (auto_clear) begin
                option0[`COW_BIT_IREG_EN] <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Register read
    // ----------------------------------------------------------------
    // Unmapped addresses read as zero; only the option word lives here
    always_comb begin
        rd_data = 16'h0000;
        if (rd_addr == `COW_REG_OPTION0) begin
            rd_data = option0;
        end
    end

    // ----------------------------------------------------------------
    // Watchdog period
    // ----------------------------------------------------------------
    logic [34:0] wd_limit;
    logic wd_off;

    function automatic logic [34:0] wd_period(input cow_wd_sel_t sel);
        unique case (sel)
            COW_WD_SHORT: wd_period = 35'(`COW_WD_SHORT_CYC);
            COW_WD_MID: wd_period = 35'(`COW_WD_MID_CYC);
            COW_WD_LONG: wd_period = 35'(`COW_WD_LONG_CYC);
            COW_WD_OFF: wd_period = 35'h0;
        endcase
    endfunction

    // A zero limit stands for a disabled watchdog
    assign wd_limit = wd_period(period_sel);
    assign wd_off = (wd_limit == 35'h0);

    // ----------------------------------------------------------------
    // Watchdog count
    // ----------------------------------------------------------------
    // Counts raw clocks with no prescaler: 35 bits hold the longest
    // period, traded against a smaller divided counter. Periods are
    // far beyond a simulation run, so expiry is seen only in systems.
    logic [34:0] wd_count;
    logic wd_kick;
    logic wd_hit;

    // Period write restarts too, so a new period takes effect cleanly
    assign wd_kick = wr_cur || wr_vol || wr_opt;
    // Last count of the period; expiry lands one edge later
    assign wd_hit = (wd_count == wd_limit - 35'h1);

    // Counter parks at expiry so it cannot wrap into a false restart
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            wd_count <= 35'h0;
        end else if (wd_kick || wd_off) begin
            wd_count <= 35'h0;
        end else if (!watchdog_expired) begin
            wd_count <= wd_count + 35'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            watchdog_expired <= 1'b0;
        end else if (wd_kick || wd_off) begin
            watchdog_expired <= 1'b0;
        end else if (wd_hit) begin
            watchdog_expired <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // Charger good
    // ----------------------------------------------------------------
    logic rev_good;

    assign rev_good = rev_good_en && reverse_source_mode;

    // Registered so the pin never glitches while the mode settles
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            charger_good_output <= 1'b0;
        end else if (adapter_good || rev_good) begin
            charger_good_output <= 1'b1;
        end else begin
            charger_good_output <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Converter controls
    // ----------------------------------------------------------------
    // Suspend forces charge current to 0 mA in the current DAC.
    // Lower option bits other than regulation enable are not decoded.
    always_comb begin
        ctrl.suspend = watchdog_expired;
        ctrl.burst_floor_en = audio_avoid;
        if (audio_avoid) begin
            ctrl.burst_floor_khz = 11'(`COW_AUDIO_MIN_KHZ);
        end else begin
            ctrl.burst_floor_khz = 11'h0;
        end
        if (freq_slow) begin
            ctrl.switch_khz = 11'(`COW_FREQ_SLOW_KHZ);
        end else begin
            ctrl.switch_khz = 11'(`COW_FREQ_FAST_KHZ);
        end
        ctrl.ireg_en = ireg_en;
        ctrl.low_power = low_power;
    end

endmodule

// ===== dv/cow_assertions.sv
// Checker for the option register, charger good and watchdog status.
// Assumes it is bound to cow_watchdog and sees only its ports.
module cow_assertions
    import cow_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst,
    input wire cow_wr_t host_wr,
    input wire logic [7:0] rd_addr,
    input wire logic [15:0] rd_data,
    input wire logic battery_present_pin,
    input wire logic reverse_source_mode,
    input wire logic adapter_good,
    input wire logic charger_good_output,
    input wire cow_ctrl_t ctrl,
    input wire logic watchdog_expired
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire logic wr12 = host_wr.valid && host_wr.addr == 8'h12;
    wire logic sel = rd_addr == 8'h12;
    sequence s_fall;
        $fell(battery_present_pin) ##0 (sel && rd_data[12]);
    endsequence
    property p_suspend;
        ctrl.suspend == watchdog_expired;
    endproperty
    a_suspend: assert property (p_suspend) else $error("suspend");
    property p_kick;
        host_wr.valid && host_wr.addr inside {8'h12, 8'h14, 8'h15}
            |=> !watchdog_expired;
    endproperty
    a_kick: assert property (p_kick) else $error("kick");
    property p_off;
        sel && rd_data[14:13] == 2'h0 |=> !watchdog_expired;
    endproperty
    a_off: assert property (p_off) else $error("period off");
    property p_auto;
        s_fall |=> !ctrl.ireg_en;
    endproperty
    a_auto: assert property (p_auto) else $error("auto off");
    property p_keep;
        $fell(battery_present_pin) && sel && !rd_data[12] && !host_wr.valid
            |=> $stable(ctrl.ireg_en);
    endproperty
    a_keep: assert property (p_keep) else $error("keep");
    property p_reen;
        wr12 && host_wr.data[1] && battery_present_pin |=> ctrl.ireg_en;
    endproperty
    a_reen: assert property (p_reen) else $error("re-enable");
    property p_good;
        adapter_good || (sel && rd_data[11] && reverse_source_mode)
            |=> charger_good_output;
    endproperty
    a_good: assert property (p_good) else $error("good");
    property p_cfg;
        wr12 |=> ctrl.burst_floor_en == $past(host_wr.data[10])
            && ctrl.switch_khz == ($past(host_wr.data[9]) ? 11'h320 : 11'h4B0);
    endproperty
    a_cfg: assert property (p_cfg) else $error("config");
endmodule

bind cow_watchdog cow_assertions chk (.*);

// ===== dv/cow_host.sv
// Host model: delivers decoded register writes as one-cycle pulses.
// Assumes writes launch on the falling edge of sys_clk.
module cow_host
    import cow_pkg::*;
(
    input wire logic sys_clk, // Clock
    output cow_wr_t host_wr // Write pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    initial host_wr = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge sys_clk);
        host_wr = '{1'b1, a, d};
        @(negedge sys_clk);
        // Released bus shows inverted data, never stale values
        host_wr = '{1'b0, ~a, ~d};
    endtask
endmodule

// ===== dv/cow_watchdog_tb.sv
// Testbench for cow_watchdog driven through the host model.
// Assumes 100 MHz; time-out periods are far beyond run length.
module cow_watchdog_tb;
    import cow_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 0, rst = 1, bat = 1, rev = 0, agood = 0;
    logic [7:0] rd_addr = 8'h12;
    logic [15:0] rd_data;
    logic cgo, wdx;
    cow_wr_t host_wr;
    cow_ctrl_t ctrl;
    int fail_count = 0, n_compared = 0;
    always #5 sys_clk = ~sys_clk;
    cow_host host (.sys_clk(sys_clk), .host_wr(host_wr));
    cow_watchdog dut (.sys_clk(sys_clk), .rst(rst), .host_wr(host_wr),
        .rd_addr(rd_addr), .rd_data(rd_data), .battery_present_pin(bat),
        .reverse_source_mode(rev), .adapter_good(agood),
        .charger_good_output(cgo), .ctrl(ctrl), .watchdog_expired(wdx));
    task automatic chk(string n, logic [15:0] e, logic [15:0] s);
        n_compared++;
        if (s !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic w(int n);
        repeat (n) @(negedge sys_clk);
    endtask
    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic t_reset;
        w(20);
        rst = 0;
        w(1);
        chk("option0", 16'hE20E, rd_data);
        chk("switch", 16'h0320, 16'(ctrl.switch_khz));
        chk("floor_en", 16'h0000, 16'(ctrl.burst_floor_en));
        chk("low_power", 16'h0001, 16'(ctrl.low_power));
        chk("suspend", 16'h0000, 16'(ctrl.suspend));
        $display("reset test done");
    endtask
    task automatic t_period;
        for (int i = 0; i < 4; i++) begin
            host.wr(8'h12, 16'h820E | (16'(i) << 13));
            chk("period", 16'(i), 16'(rd_data[14:13]));
            chk("expired", 16'h0000, 16'(wdx));
        end
        $display("period test done");
    endtask
    task automatic t_config;
        host.wr(8'h12, 16'hE40E);
        chk("switch", 16'h04B0, 16'(ctrl.switch_khz));
        chk("floor", 16'h0019, 16'(ctrl.burst_floor_khz));
        chk("floor_en", 16'h0001, 16'(ctrl.burst_floor_en));
        chk("low_power", 16'h0001, 16'(ctrl.low_power));
        $display("config test done");
    endtask
    task automatic t_auto;
        host.wr(8'h12, 16'hF40E);
        bat = 0;
        w(2);
        chk("option0", 16'hF40C, rd_data);
        host.wr(8'h12, 16'hF40E);
        chk("ireg_en", 16'h0001, 16'(ctrl.ireg_en));
        host.wr(8'h12, 16'hE40E);
        bat = 1;
        w(2);
        bat = 0;
        w(2);
        chk("ireg_en", 16'h0001, 16'(ctrl.ireg_en));
        $display("auto-off test done");
    endtask
    task automatic t_good;
        rev = 1;
        w(2);
        chk("good", 16'h0000, 16'(cgo));
        host.wr(8'h12, 16'hEC0E);
        w(1);
        chk("good", 16'h0001, 16'(cgo));
        $display("good test done");
    endtask
    task automatic t_kick;
        host.wr(8'h14, 16'h1234);
        host.wr(8'h15, 16'h4321);
        host.wr(8'h20, 16'h0000);
        chk("option0", 16'hEC0E, rd_data);
        chk("expired", 16'h0000, 16'(wdx));
        chk("suspend", 16'h0000, 16'(ctrl.suspend));
        $display("kick test done");
    endtask
    initial begin
        t_reset;
        t_period;
        t_config;
        t_auto;
        t_good;
        t_kick;
        summarize;
    end
endmodule
